// *** acmd_pkg.sv ***
/*
  Constants, field layouts and types shared by the codec command port.
  Assumes a 125 MHz system clock and a codec that drives the bit clock.
*/
`default_nettype none

package acmd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_OFS     = 8'h20;
  localparam logic [7:0]  STAT_OFS    = 8'h24;
  localparam logic [7:0]  CTRL_OFS    = 8'h30;
  localparam logic [7:0]  ISTAT_OFS   = 8'h34;
  localparam logic [7:0]  IMASK_OFS   = 8'h38;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] CMD_RST     = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RST     = 2'h0;
  localparam int          WARM_BIT    = 13;
  localparam int          IRQ_WDONE   = 0;
  localparam int          IRQ_RDATA   = 1;
  localparam int          TAG_FRAME   = 15;
  localparam int          TAG_SLOT1   = 14;
  localparam int          TAG_SLOT2   = 13;
  localparam int          RX_IDX_HI   = 18;
  localparam int          RX_IDX_LO   = 12;
  localparam int          RX_DAT_HI   = 19;
  localparam int          RX_DAT_LO   = 4;

  // ----------------------------------------------------------------
  // Frame layout in bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  BIT_LAST    = 8'hFF;
  localparam logic [7:0]  SLOT0_LAST  = 8'h0F;
  localparam logic [7:0]  SLOT1_LAST  = 8'h23;
  localparam logic [7:0]  SLOT2_LAST  = 8'h37;
  localparam int          TX_W        = 56;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_NS      = 8;
  localparam int          WARM_US     = 1;
  localparam int          WARM_CYC    = (WARM_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  WARM_LAST   = 8'(WARM_CYC - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  rsvd;
    logic        pdown;
    logic        go;
    logic [15:0] data;
    logic        rw;
    logic [6:0]  idx;
  } acmd_cmd_type;

  typedef struct packed {
    logic [6:0]  rsvd;
    logic        ready;
    logic        valid;
    logic [6:0]  idx;
    logic [15:0] data;
  } acmd_stat_type;

  typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WARM} acmd_state_type;

endpackage : acmd_pkg

`default_nettype wire

// *** acmd_sync.sv ***
/*
  Two flip-flop synchroniser for a group of asynchronous inputs.
  Assumes the caller reads only q; the first stage stays internal.
*/
`timescale 1ns/1ps
`default_nettype none

module acmd_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : acmd_sync

`default_nettype wire

// *** acmd_top.sv ***
/*
  Codec command port of an AC-link controller: frame timing, command
  slots, read-back capture, warm reset, power-down and interrupts.
  Assumes the codec drives bit_clk and sdata_in; both are asynchronous.
*/
// Operation
// RQ1 - Register address goes in slot 1, command data in slot 2.
// RQ2 - A requested command runs in the next frame, never the current one.
// RQ3 - Status and interrupt on write completion and on read data arrival.
// RQ4 - Power-down flag on a write zeroes all link outputs after slot 2.
// RQ5 - Software clears power-down flag before requesting warm reset.
// RQ6 - Go bit sends address and data next frame, then clears itself.
// RQ7 - Software sets index, direction and payload with the go write.
// RQ8 - Payload goes out in slot 2 only for a write.
// RQ9 - Direction bit is copied to the read/write bit of slot 1.
// RQ10 - Seven-bit register index goes in the slot 1 address field.
// RQ11 - Warm reset holds sync high one microsecond, then self-clears.
// RQ12 - Read-data-valid clears on a read request, sets when data returns.
// RQ13 - Result signalled only after index and data of a later frame.
`timescale 1ns/1ps
`default_nettype none

module acmd_top
  import acmd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata_ff,
  output var  logic        irq_ff,
  input  wire logic        bit_clk,
  input  wire logic        sdata_in,
  output var  logic        sync_ff,
  output var  logic        sdata_out_ff
);

  logic           rst_meta_ff;
  logic           rst_sync_n_ff;
  logic [1:0]     pin_s;
  logic           bclk_d_ff;
  logic           rise;
  logic           fall;
  acmd_cmd_type   cmd_ff;
  acmd_cmd_type   live_ff;
  logic           warm_ff;
  acmd_state_type state_ff;
  logic [7:0]     warm_cnt_ff;
  logic [7:0]     bit_cnt_ff;
  logic [TX_W-1:0] tx_sr_ff;
  logic [TX_W-1:0] nxt_frame;
  logic [19:0]    rx_sr_ff;
  logic           tag_s1_ff;
  logic           tag_s2_ff;
  logic           idx_got_ff;
  logic [6:0]     rx_idx_ff;
  logic           rd_pend_ff;
  acmd_stat_type  stat_ff;
  logic [1:0]     istat_ff;
  logic [1:0]     imask_ff;
  logic [1:0]     events;
  logic           cmd_wr;
  logic           cmd_done;
  logic           rd_result;

  // ----------------------------------------------------------------
  // Reset release and pin sampling
  // ----------------------------------------------------------------

  // Reset released through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  acmd_sync #(.W(2)) u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_sync_n_ff),
    .ce    (ce),
    .d     ({bit_clk, sdata_in}),
    .q     (pin_s)
  );

  // Bit clock edge finder
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      bclk_d_ff <= 1'b0;
    end else if (ce) begin
      bclk_d_ff <= pin_s[1];
    end
  end

  assign rise     = pin_s[1] & ~bclk_d_ff;
  assign fall     = ~pin_s[1] & bclk_d_ff;
  assign cmd_wr   = reg_wr && (reg_addr == CMD_OFS);
  assign cmd_done = rise && (state_ff == ST_RUN) && (bit_cnt_ff == SLOT2_LAST) && live_ff.go;

  // ----------------------------------------------------------------
  // Command and control registers
  // ----------------------------------------------------------------

  // Command register, go bit self-clears after slot 2
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      cmd_ff <= acmd_cmd_type'(CMD_RST);
    end else if (ce) begin
      if (cmd_wr) begin
        cmd_ff      <= acmd_cmd_type'(reg_wdata);
        cmd_ff.rsvd <= '0;
      end else if (cmd_done) begin
        cmd_ff.go <= 1'b0; // RQ6
      end
    end
  end

  // Warm reset request, cleared when the pulse ends
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      warm_ff <= 1'b0;
    end else if (ce) begin
      if (reg_wr && (reg_addr == CTRL_OFS)) begin
        warm_ff <= reg_wdata[WARM_BIT];
      end else if ((state_ff == ST_WARM) && (warm_cnt_ff == WARM_LAST)) begin
        warm_ff <= 1'b0; // RQ11
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      imask_ff <= IRQ_RST;
    end else if (ce && reg_wr && (reg_addr == IMASK_OFS)) begin
      imask_ff <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Link state: running, powered down, warm reset pulse
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      state_ff    <= ST_RUN;
      warm_cnt_ff <= 8'h00;
    end else if (ce) begin
      case (state_ff)
        ST_RUN: begin
          if (warm_ff) begin
            state_ff    <= ST_WARM;
            warm_cnt_ff <= 8'h00;
          end else if (cmd_done && live_ff.pdown && !live_ff.rw) begin
            state_ff <= ST_OFF; // RQ4
          end
        end
        ST_OFF: begin
          if (warm_ff) begin
            state_ff    <= ST_WARM;
            warm_cnt_ff <= 8'h00;
          end
        end
        ST_WARM: begin
          if (warm_cnt_ff == WARM_LAST) begin
            state_ff <= ST_RUN; // RQ11
          end else begin
            warm_cnt_ff <= warm_cnt_ff + 8'h01;
          end
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit frame
  // ----------------------------------------------------------------

  // Tag, slot 1 and slot 2 of the coming frame
  always_comb begin
    nxt_frame = '0;
    nxt_frame[TX_W-1-TAG_FRAME+15] = 1'b1;
    if (cmd_ff.go) begin
      nxt_frame[TX_W-1-(15-TAG_SLOT1)]  = 1'b1;                         // RQ1
      nxt_frame[TX_W-1-(15-TAG_SLOT2)]  = ~cmd_ff.rw;                   // RQ8
      nxt_frame[TX_W-17]                = cmd_ff.rw;                    // RQ9
      nxt_frame[TX_W-18 -: 7]           = cmd_ff.idx;                   // RQ10
      nxt_frame[TX_W-37 -: 16]          = cmd_ff.rw ? 16'h0000 : cmd_ff.data; // RQ8
    end
  end

  // Frame counter, shifter, sync and data out
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      bit_cnt_ff   <= BIT_LAST;
      tx_sr_ff     <= '0;
      live_ff      <= acmd_cmd_type'(CMD_RST);
      sync_ff      <= 1'b0;
      sdata_out_ff <= 1'b0;
    end else if (ce) begin
      case (state_ff)
        ST_RUN: begin
          if (rise && (bit_cnt_ff == BIT_LAST)) begin
            bit_cnt_ff   <= 8'h00;
            tx_sr_ff     <= {nxt_frame[TX_W-2:0], 1'b0};
            live_ff      <= cmd_ff; // RQ2
            sync_ff      <= 1'b1;
            sdata_out_ff <= nxt_frame[TX_W-1];
          end else if (rise) begin
            bit_cnt_ff   <= bit_cnt_ff + 8'h01;
            tx_sr_ff     <= {tx_sr_ff[TX_W-2:0], 1'b0};
            sync_ff      <= (bit_cnt_ff < SLOT0_LAST);
            sdata_out_ff <= tx_sr_ff[TX_W-1];
          end
          // Sync rises with the state change so the pulse is a full 1 us
          if (warm_ff) begin
            sync_ff <= 1'b1; // RQ11
          end
        end
        ST_WARM: begin
          bit_cnt_ff   <= BIT_LAST;
          live_ff      <= acmd_cmd_type'(CMD_RST);
          sync_ff      <= (warm_cnt_ff != WARM_LAST); // RQ11
          sdata_out_ff <= 1'b0;
        end
        default: begin
          live_ff      <= acmd_cmd_type'(CMD_RST);
          sync_ff      <= warm_ff; // RQ4 RQ11
          sdata_out_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive path: tag, echoed index, read data
  // ----------------------------------------------------------------
  assign rd_result = fall && (state_ff == ST_RUN) && (bit_cnt_ff == SLOT2_LAST) &&
                     rd_pend_ff && idx_got_ff && tag_s2_ff;

  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      rx_sr_ff   <= 20'h00000;
      tag_s1_ff  <= 1'b0;
      tag_s2_ff  <= 1'b0;
      idx_got_ff <= 1'b0;
      rx_idx_ff  <= 7'h00;
    end else if (ce && fall && (state_ff == ST_RUN)) begin
      rx_sr_ff <= {rx_sr_ff[18:0], pin_s[0]};
      if (bit_cnt_ff == SLOT0_LAST) begin
        tag_s1_ff  <= rx_sr_ff[TAG_SLOT1-1];
        tag_s2_ff  <= rx_sr_ff[TAG_SLOT2-1];
        idx_got_ff <= 1'b0;
      end else if ((bit_cnt_ff == SLOT1_LAST) && tag_s1_ff) begin
        rx_idx_ff  <= rx_sr_ff[RX_IDX_HI-1 -: 7]; // RQ13
        idx_got_ff <= 1'b1;
      end
    end
  end

  // Read pending from request frame to a later result
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      rd_pend_ff <= 1'b0;
    end else if (ce) begin
      if (cmd_done && live_ff.rw) begin
        rd_pend_ff <= 1'b1; // RQ13
      end else if (rd_result) begin
        rd_pend_ff <= 1'b0;
      end
    end
  end

  // Codec ready from each received tag, read data, index and valid flag
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      stat_ff.rsvd  <= '0;
      stat_ff.ready <= 1'b0;
      stat_ff.valid <= 1'b0;
      stat_ff.idx   <= 7'h00;
      stat_ff.data  <= 16'h0000;
    end else if (ce) begin
      if (fall && (state_ff == ST_RUN) && (bit_cnt_ff == SLOT0_LAST)) begin
        stat_ff.ready <= rx_sr_ff[TAG_FRAME-1];
      end
      if (rd_result) begin
        stat_ff.valid <= 1'b1; // RQ12
        stat_ff.idx   <= rx_idx_ff;
        stat_ff.data  <= rx_sr_ff[RX_DAT_HI-1:RX_DAT_LO-1];
      end else if (cmd_wr && reg_wdata[24] && reg_wdata[7]) begin
        stat_ff.valid <= 1'b0; // RQ12
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign events = {rd_result, cmd_done && !live_ff.rw}; // RQ3

  // Sticky status, read clears, new event wins
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      istat_ff <= IRQ_RST;
      irq_ff   <= 1'b0;
    end else if (ce) begin
      if (reg_rd && (reg_addr == ISTAT_OFS)) begin
        istat_ff <= events;
      end else begin
        istat_ff <= istat_ff | events; // RQ3
      end
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      reg_rdata_ff <= ZERO_WORD;
    end else if (ce) begin
      reg_rdata_ff <= ZERO_WORD;
      if (reg_rd) begin
        case (reg_addr)
          CMD_OFS:   reg_rdata_ff <= cmd_ff;
          STAT_OFS:  reg_rdata_ff <= stat_ff;
          CTRL_OFS:  reg_rdata_ff <= {18'h00000, warm_ff, 13'h0000};
          ISTAT_OFS: reg_rdata_ff <= {30'h00000000, istat_ff};
          IMASK_OFS: reg_rdata_ff <= {30'h00000000, imask_ff};
          default:   reg_rdata_ff <= ZERO_WORD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n_ff || !ce);

  a_go_self_clear: assert property ( // RQ6
    cmd_done && !cmd_wr |=> !cmd_ff.go) else $error("go bit not cleared after slot 2");

  a_next_frame: assert property ( // RQ2
    rise && (state_ff == ST_RUN) && (bit_cnt_ff == BIT_LAST) && cmd_ff.go |=> live_ff.go
  ) else $error("pending command not taken at frame start");

  a_slot1_dir: assert property ( // RQ9
    rise && (state_ff == ST_RUN) && (bit_cnt_ff == SLOT0_LAST) |=>
      sdata_out_ff == (live_ff.go & live_ff.rw)) else $error("slot 1 direction bit wrong");

  a_slot1_index: assert property ( // RQ10
    rise && (state_ff == ST_RUN) && (bit_cnt_ff == 8'h10) |=>
      sdata_out_ff == (live_ff.go & live_ff.idx[6])) else $error("slot 1 index bit wrong");

  a_slot2_data: assert property ( // RQ8
    rise && (state_ff == ST_RUN) && (bit_cnt_ff == SLOT1_LAST) |=>
      sdata_out_ff == (live_ff.go & !live_ff.rw & live_ff.data[15]))
    else $error("slot 2 payload bit wrong");

  a_pdown_quiet: assert property ( // RQ4
    (state_ff == ST_OFF) && !warm_ff |=> !sync_ff && !sdata_out_ff)
    else $error("link active in power-down");

  a_warm_end: assert property ( // RQ11
    (state_ff == ST_WARM) && (warm_cnt_ff == WARM_LAST) |=> (state_ff == ST_RUN) && !warm_ff
  ) else $error("warm reset did not end cleanly");

  a_warm_sync: assert property ( // RQ11
    $rose(state_ff == ST_WARM) |=> sync_ff [*8]) else $error("sync low during warm reset");

  a_rdv_clear: assert property ( // RQ12
    cmd_wr && reg_wdata[24] && reg_wdata[7] && !rd_result |=> !stat_ff.valid
  ) else $error("valid flag kept on read request");

  a_result_pair: assert property ( // RQ13
    $rose(stat_ff.valid) |-> $past(idx_got_ff) && $past(rd_pend_ff)
  ) else $error("result without echoed index");

  a_irq_event: assert property ( // RQ3
    events[IRQ_WDONE] && imask_ff[IRQ_WDONE] && $stable(imask_ff) |=> ##1 irq_ff
  ) else $error("write completion raised no interrupt");

  c_write_done: cover property (cmd_done && !live_ff.rw);
  c_read_back:  cover property (rd_result);
  c_power_down: cover property ($rose(state_ff == ST_OFF));
  c_warm_wake:  cover property ($fell(state_ff == ST_WARM));

endmodule : acmd_top

`default_nettype wire

// *** acmd_codec_model.sv ***
/*
  Behavioural codec at the far end of the AC-link: bit clock, frame
  decoding of the command slots, and read-back answers.
  Assumes the port under test frames with sync and shifts MSB first.
*/
`timescale 1ns/1ps
`default_nettype none

module acmd_codec_model (
  output var  logic        bit_clk,
  output var  logic        sdata_in,
  input  wire logic        sync,
  input  wire logic        sdata_out,
  output var  int          frames,
  output var  logic [15:0] tag_seen,
  output var  logic [19:0] slot1_seen,
  output var  logic [19:0] slot2_seen
);
  localparam logic [15:0] DATA_KEY = 16'hA5C3;
  logic [7:0]  cnt;
  logic [7:0]  nxt_bit;
  logic        sync_q;
  logic        hi_seen;
  logic        rd_pend;
  logic [6:0]  rd_idx;
  logic [55:0] shf;
  logic [55:0] resp;

  // ----------------------------------------------------------------
  // Clock and start state
  // ----------------------------------------------------------------
  initial begin
    cnt = 8'hFF;
    sync_q = 1'b0;
    hi_seen = 1'b0;
    rd_pend = 1'b0;
    rd_idx = 7'h00;
    shf = '0;
    resp = '0;
    frames = 0;
    tag_seen = 16'h0000;
    slot1_seen = 20'h00000;
    slot2_seen = 20'h00000;
    sdata_in = 1'b0;
    bit_clk = 1'b0;
    forever #80 bit_clk = ~bit_clk;
  end

  // Sample outgoing bits; sync edges realign the bit count
  always @(negedge bit_clk) begin
    if (sync && !sync_q) cnt = 8'h00;
    else if (!sync && sync_q) cnt = 8'h10; // Bit after the 16-bit tag
    else cnt = cnt + 8'h01;
    sync_q = sync;
    if (sync) hi_seen = 1'b1;
    shf = {shf[54:0], sdata_out};
    if (cnt == 8'h37 && hi_seen) begin
      frames++;
      hi_seen = 1'b0;
      tag_seen = shf[55:40];
      slot1_seen = shf[39:20];
      slot2_seen = shf[19:0];
      if (shf[54] && shf[39]) begin
        rd_pend = 1'b1;
        rd_idx = shf[38:32];
      end
    end
  end

  // Answer a read in the next frame; idle bits sit at the pull-down level
  always @(posedge bit_clk) begin
    nxt_bit = cnt + 8'h01;
    if (nxt_bit == 8'h00) begin
      resp = {1'b1, rd_pend, rd_pend, 13'h0000, 1'b0, rd_idx, 12'h000,
              DATA_KEY ^ {9'h000, rd_idx}, 4'h0};
      rd_pend = 1'b0;
    end
    sdata_in = (nxt_bit < 8'h38) ? resp[8'h37 - nxt_bit] : 1'b0;
  end
endmodule : acmd_codec_model

`default_nettype wire

// *** ac_link_codec_command_port_bench.sv ***
/*
  Self-checking bench of the codec command port: register tasks,
  command frames, read-back, interrupts, power-down and warm reset.
  Assumes the codec model drives the link clock at 160 ns.
*/
`timescale 1ns/1ps
`default_nettype none

module ac_link_codec_command_port_bench
  import acmd_pkg::*;
;
  localparam logic [15:0] DATA_KEY = 16'hA5C3;
  logic        mclk, rst_n, ce, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, rv;
  wire  logic [31:0] reg_rdata_ff;
  wire  logic  irq_ff, bit_clk, sdata_in, sync_ff, sdata_out_ff;
  int          frames, failures, samples_checked, n;
  logic [15:0] tag_seen;
  logic [19:0] slot1_seen, slot2_seen;

  acmd_top dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .irq_ff(irq_ff), .bit_clk(bit_clk), .sdata_in(sdata_in), .sync_ff(sync_ff),
    .sdata_out_ff(sdata_out_ff));
  acmd_codec_model codec_u (.bit_clk(bit_clk), .sdata_in(sdata_in), .sync(sync_ff),
    .sdata_out(sdata_out_ff), .frames(frames), .tag_seen(tag_seen),
    .slot1_seen(slot1_seen), .slot2_seen(slot2_seen));

  // ----------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic test_done();
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // Cuts a hung run after roughly 17 frames
  initial begin
    #700_000;
    failures++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask : reg_read

  task automatic check_reg(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_read(a, d);
    chk(what, e, d);
  endtask : check_reg

  task automatic wait_frame();
    int f0;
    int k;
    f0 = frames;
    k = 0;
    while (frames == f0 && k < 7000) begin
      @(posedge mclk);
      k++;
    end
    chk("frame_seen", 32'h1, 32'(frames != f0));
  endtask : wait_frame

  // Command write early in a frame; that frame stays idle, the next carries it
  task automatic send_cmd(input logic [31:0] c);
    int k;
    k = 0;
    while (sync_ff !== 1'b1 && k < 7000) begin
      @(posedge mclk);
      k++;
    end
    repeat (20) @(posedge mclk);
    reg_write(CMD_OFS, c);
    wait_frame();
    chk("slots_current", 32'h0, 32'(tag_seen[14:13]));
    wait_frame();
    chk("slot_tags", 32'({1'b1, ~c[7]}), 32'(tag_seen[14:13]));
    chk("slot1", 32'({c[7], c[6:0], 12'h000}), 32'(slot1_seen));
    chk("slot2", c[7] ? 32'h0 : 32'({c[23:8], 4'h0}), 32'(slot2_seen));
    repeat (40) @(posedge mclk);
    check_reg("command", CMD_OFS, c & 32'hFEFF_FFFF);
  endtask : send_cmd

  task automatic read_cmd(input logic [6:0] idx);
    logic [31:0] st;
    send_cmd({8'h01, 16'h0000, 1'b1, idx});
    reg_read(STAT_OFS, st);
    chk("valid_cleared", 32'h0, 32'(st[23]));
    k_irq: for (int k = 0; k < 7000 && irq_ff !== 1'b1; k++) @(posedge mclk);
    chk("irq_read", 32'h1, 32'(irq_ff));
    check_reg("status", STAT_OFS, {7'h00, 1'b1, 1'b1, idx, DATA_KEY ^ {9'h000, idx}});
    check_reg("irq_status", ISTAT_OFS, 32'h2);
    repeat (3) @(posedge mclk);
    chk("irq_cleared", 32'h0, 32'(irq_ff));
  endtask : read_cmd

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset values and an unmapped place
    check_reg("command_reset", CMD_OFS, CMD_RST);
    check_reg("mask_reset", IMASK_OFS, 32'h0);
    check_reg("unmapped", 8'h10, 32'h0);
    chk("irq_reset", 32'h0, 32'(irq_ff));
    // Masked write: status set, no interrupt
    send_cmd(32'h01BE_EF2C);
    chk("irq_masked", 32'h0, 32'(irq_ff));
    check_reg("irq_status", ISTAT_OFS, 32'h1);
    check_reg("irq_status_clr", ISTAT_OFS, 32'h0);
    // Two reads, second clears valid on request
    reg_write(IMASK_OFS, 32'h3);
    read_cmd(7'h7C);
    read_cmd(7'h02);
    // Power-down write then silence
    send_cmd(32'h0380_0026);
    n = 0;
    repeat (6000) begin
      @(posedge mclk);
      if (sync_ff !== 1'b0 || sdata_out_ff !== 1'b0) n++;
    end
    chk("pdown_activity", 32'h0, 32'(n));
    // Clear power-down flag, then warm reset
    reg_write(CMD_OFS, 32'h0);
    reg_write(CTRL_OFS, 32'h1 << WARM_BIT);
    for (int k = 0; k < 5 && sync_ff !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    n = 1;
    while (n < 300) begin
      @(posedge mclk);
      #1;
      if (sync_ff !== 1'b1) break;
      n++;
    end
    chk("warm_cycles", 32'd125, 32'(n));
    reg_read(CTRL_OFS, rv);
    chk("warm_request", 32'h0, 32'(rv[WARM_BIT]));
    // Framing restarts after wake
    send_cmd(32'h0112_3418);
    test_done();
  end
endmodule : ac_link_codec_command_port_bench

`default_nettype wire
